/* touch_feature_command_decoder.sv */
// Feature command decoder: setup check, data-stage parse, report routing
`timescale 1ns/1ps
module touch_feature_command_decoder
(
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  setup_valid,
    input  wire logic [7:0]            setup_req_type,
    input  wire logic [7:0]            setup_req_code,
    input  wire logic [15:0]           setup_value,
    input  wire logic [15:0]           setup_index,
    input  wire logic [15:0]           setup_length,
    input  wire logic                  out_data_valid,
    input  wire logic [7:0]            out_data,
    input  wire logic                  touch_data_ready,
    input  wire logic                  calibrate_busy,
    output logic                       ep0_stall,
    output logic                       cmd_done,
    output feature_pkg::command_t      cmd_code,
    output logic [7:0]                 cmd_arg,
    output logic                       reports_enabled,
    output logic                       tool_mode,
    output logic [7:0]                 active_report_ident,
    output logic                       ep1_send,
    output logic                       ep0_send,
    output logic [7:0]                 send_report_ident
);
    import feature_pkg::*;

    // ==========================================================
    // Setup classification
    // ==========================================================
    setup_fields_if fields();

    assign fields.req_type = setup_req_type;
    assign fields.req_code = setup_req_code;
    assign fields.value    = setup_value;
    assign fields.index    = setup_index;
    assign fields.length   = setup_length;

    setup_checker checker_inst
    (
        .fields (fields)
    );

    // ==========================================================
    // Command sequencer
    // ==========================================================
    typedef enum logic [1:0] {
        IDLE,
        DATA,
        EXECUTE
    } seq_state_t;

    seq_state_t  state;
    seq_state_t  next_state;
    logic [2:0]  byte_pos;
    logic [2:0]  next_byte_pos;
    logic [7:0]  ident;
    logic [7:0]  next_ident;
    logic [7:0]  subtype;
    logic [7:0]  next_subtype;
    logic [7:0]  selector;
    logic [7:0]  next_selector;
    logic [7:0]  arg;
    logic [7:0]  next_arg;
    logic [7:0]  setup_ident;
    logic [7:0]  next_setup_ident;
    logic        ep0_stall_next;
    logic        cmd_done_next;
    command_t    cmd_code_next;
    logic [7:0]  cmd_arg_next;
    logic        apply_select;

    always_comb
    begin
        next_state       = state;
        next_byte_pos    = byte_pos;
        next_ident       = ident;
        next_subtype     = subtype;
        next_selector    = selector;
        next_arg         = arg;
        next_setup_ident = setup_ident;
        ep0_stall_next   = 1'b0;
        cmd_done_next    = 1'b0;
        cmd_code_next    = cmd_code;
        cmd_arg_next     = cmd_arg;
        apply_select     = 1'b0;
        case (state)
            IDLE:
            begin
                if (setup_valid)
                begin
                    if (!fields.valid)
                        ep0_stall_next = 1'b1;
                    else if (fields.command == CMD_SELECT)
                    begin
                        next_setup_ident = setup_value[7:0];
                        next_byte_pos    = DS_ID_POS;
                        next_state       = DATA;
                    end
                    else
                    begin
                        // Get requests handed to the payload logic
                        cmd_done_next = 1'b1;
                        cmd_code_next = fields.command;
                        cmd_arg_next  = '0;
                    end
                end
            end
            DATA:
            begin
                if (out_data_valid)
                begin
                    case (byte_pos)
                        DS_ID_POS:       next_ident    = out_data;
                        DS_SUBTYPE_POS:  next_subtype  = out_data;
                        DS_SELECTOR_POS: next_selector = out_data;
                        default:         next_arg      = arg;
                    endcase
                    // Calibration type rides in byte 2
                    if (byte_pos == DS_SUBTYPE_POS + 3'h1)
                        next_arg = out_data;
                    next_byte_pos = byte_pos + 3'h1;
                    if (byte_pos == DS_LAST_POS)
                        next_state = EXECUTE;
                end
            end
            EXECUTE:
            begin
                next_state = IDLE;
                cmd_arg_next = arg;
                if (ident != setup_ident)
                    ep0_stall_next = 1'b1;
                else if (ident == CTRL_NUM_ID && subtype == SUB_CTRL_NUM)
                begin
                    cmd_done_next = 1'b1;
                    cmd_code_next = CMD_SET_CTRL_NUM;
                end
                else if (ident != CMD_FEATURE_ID)
                    ep0_stall_next = 1'b1;
                else
                begin
                    case (subtype)
                        SUB_SELECT:
                        begin
                            if (selector == SEL_OFF || selector == SEL_ON
                                || selector == SEL_STANDARD || selector == SEL_PACKED
                                || selector == SEL_TOOL || selector == SEL_RESTORE)
                            begin
                                apply_select  = 1'b1;
                                cmd_done_next = 1'b1;
                                cmd_code_next = CMD_SELECT;
                                cmd_arg_next  = selector;
                            end
                            else
                                ep0_stall_next = 1'b1;
                        end
                        SUB_CALIBRATE:
                        begin
                            // Busy calibration forbids a second start
                            if (calibrate_busy)
                                ep0_stall_next = 1'b1;
                            else
                            begin
                                cmd_done_next = 1'b1;
                                cmd_code_next = CMD_CALIBRATE;
                            end
                        end
                        SUB_RESET:
                        begin
                            apply_select  = 1'b1;
                            cmd_done_next = 1'b1;
                            cmd_code_next = CMD_RESET;
                        end
                        SUB_DEFAULTS:
                        begin
                            cmd_done_next = 1'b1;
                            cmd_code_next = CMD_DEFAULTS;
                        end
                        default:
                            ep0_stall_next = 1'b1;
                    endcase
                end
            end
            default:
                next_state = IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state       <= IDLE;
            byte_pos    <= DS_ID_POS;
            ident       <= '0;
            subtype     <= '0;
            selector    <= '0;
            arg         <= '0;
            setup_ident <= '0;
            ep0_stall   <= 1'b0;
            cmd_done    <= 1'b0;
            cmd_code    <= CMD_NONE;
            cmd_arg     <= '0;
        end
        else
        begin
            state       <= next_state;
            byte_pos    <= next_byte_pos;
            ident       <= next_ident;
            subtype     <= next_subtype;
            selector    <= next_selector;
            arg         <= next_arg;
            setup_ident <= next_setup_ident;
            ep0_stall   <= ep0_stall_next;
            cmd_done    <= cmd_done_next;
            cmd_code    <= cmd_code_next;
            cmd_arg     <= cmd_arg_next;
        end
    end

    // ==========================================================
    // Report selection
    // ==========================================================
    logic [7:0] next_active;
    logic       next_enabled;
    logic       next_tool;

    always_comb
    begin
        next_active  = active_report_ident;
        next_enabled = reports_enabled;
        next_tool    = tool_mode;
        if (apply_select && subtype == SUB_RESET)
        begin
            // Reset command returns to power-up selection
            next_active  = standard_report_ident;
            next_enabled = 1'b1;
            next_tool    = 1'b0;
        end
        else if (apply_select)
        begin
            case (selector)
                SEL_OFF:      next_enabled = 1'b0;
                SEL_ON:       next_enabled = 1'b1;
                SEL_STANDARD: next_active  = standard_report_ident;
                SEL_PACKED:   next_active  = dual_point_report_ident;
                SEL_TOOL:     next_tool    = 1'b1;
                SEL_RESTORE:  next_tool    = 1'b0;
                default:      next_tool    = tool_mode;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            active_report_ident <= standard_report_ident;
            reports_enabled     <= 1'b1;
            tool_mode           <= 1'b0;
        end
        else
        begin
            active_report_ident <= next_active;
            reports_enabled     <= next_enabled;
            tool_mode           <= next_tool;
        end
    end

    // ==========================================================
    // Report dispatch
    // ==========================================================
    logic       next_ep1_send;
    logic       next_ep0_send;
    logic [7:0] next_send_ident;

    always_comb
    begin
        next_ep1_send   = 1'b0;
        next_ep0_send   = 1'b0;
        next_send_ident = send_report_ident;
        if (touch_data_ready && reports_enabled)
        begin
            if (tool_mode)
            begin
                next_ep0_send   = 1'b1;
                next_send_ident = tool_report_ident;
            end
            else
            begin
                next_ep1_send   = 1'b1;
                next_send_ident = active_report_ident;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ep1_send          <= 1'b0;
            ep0_send          <= 1'b0;
            send_report_ident <= standard_report_ident;
        end
        else
        begin
            ep1_send          <= next_ep1_send;
            ep0_send          <= next_ep0_send;
            send_report_ident <= next_send_ident;
        end
    end

endmodule

/* feature_pkg.sv */
// Constants and types for the touch feature command decoder
package feature_pkg;

    // Request-type byte fields
    localparam int DIR_BIT       = 7;
    localparam int TYPE_HI       = 6;
    localparam int TYPE_LO       = 5;
    localparam int RCPT_HI       = 4;
    localparam int RCPT_LO       = 0;
    localparam logic [1:0] TYPE_STANDARD = 2'h0;
    localparam logic [1:0] TYPE_CLASS    = 2'h1;
    localparam logic [1:0] TYPE_VENDOR   = 2'h2;
    localparam logic [4:0] RCPT_DEVICE   = 5'h00;
    localparam logic [4:0] RCPT_IFACE    = 5'h01;

    // Setup-packet values and data-stage subtypes
    localparam logic [7:0]  SET_REQ_TYPE     = 8'h21;
    localparam logic [7:0]  GET_REQ_TYPE     = 8'ha1;
    localparam logic [7:0]  SET_REPORT_CODE  = 8'h09;
    localparam logic [7:0]  GET_REPORT_CODE  = 8'h01;
    localparam logic [7:0]  FEATURE_KIND     = 8'h03;
    localparam logic [7:0]  CMD_FEATURE_ID   = 8'h03;
    localparam logic [7:0]  CTRL_NUM_ID      = 8'h05;
    localparam logic [7:0]  STATUS_ID        = 8'h06;
    localparam logic [7:0]  SUB_CALIBRATE    = 8'h04;
    localparam logic [7:0]  SUB_SELECT       = 8'h05;
    localparam logic [7:0]  SUB_RESET        = 8'h07;
    localparam logic [7:0]  SUB_DEFAULTS     = 8'h08;
    localparam logic [7:0]  SUB_CTRL_NUM     = 8'h01;
    localparam logic [15:0] SHORT_LEN        = 16'h0008;
    localparam logic [15:0] CTRL_NUM_LEN     = 16'h0048;
    localparam logic [15:0] LEN_ALIGN_MASK   = 16'h0007;

    // Data-stage byte positions
    localparam logic [2:0] DS_ID_POS       = 3'h0;
    localparam logic [2:0] DS_SUBTYPE_POS  = 3'h1;
    localparam logic [2:0] DS_SELECTOR_POS = 3'h4;
    localparam logic [2:0] DS_LAST_POS     = 3'h7;

    // Report selector codes
    localparam logic [7:0] SEL_OFF      = 8'h00;
    localparam logic [7:0] SEL_ON       = 8'h01;
    localparam logic [7:0] SEL_STANDARD = 8'h02;
    localparam logic [7:0] SEL_PACKED   = 8'h03;
    localparam logic [7:0] SEL_TOOL     = 8'h06;
    localparam logic [7:0] SEL_RESTORE  = 8'h07;

    // Report identifiers
    localparam logic [7:0] standard_report_ident   = 8'h01;
    localparam logic [7:0] dual_point_report_ident = 8'h02;
    localparam logic [7:0] tool_report_ident       = 8'h07;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_SELECT,
        CMD_CALIBRATE,
        CMD_RESET,
        CMD_DEFAULTS,
        CMD_SET_CTRL_NUM,
        CMD_STATUS,
        CMD_GET_CTRL_NUM
    } command_t;

endpackage

/* setup_fields_if.sv */
// Raw setup-packet fields passed to the checker, and its decoded command and valid flag passed back to the sequencer
`timescale 1ns/1ps
interface setup_fields_if;
    import feature_pkg::*;
    logic [7:0]  req_type;
    logic [7:0]  req_code;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
    command_t    command;
    logic        valid;

    modport source (input req_type, req_code, value, index, length,
                    output command, valid);
    modport sink   (output req_type, req_code, value, index, length,
                    input command, valid);
endinterface

/* setup_checker.sv */
// Combinational classifier of a setup packet into a feature command
`timescale 1ns/1ps
module setup_checker
(
    setup_fields_if.source fields
);
    import feature_pkg::*;

    logic [7:0] kind;
    logic [7:0] ident;
    logic       dir_in;
    logic [1:0] req_kind;
    logic [4:0] rcpt;

    always_comb
    begin
        kind     = fields.value[15:8];
        ident    = fields.value[7:0];
        dir_in   = fields.req_type[DIR_BIT];
        req_kind = fields.req_type[TYPE_HI:TYPE_LO];
        rcpt     = fields.req_type[RCPT_HI:RCPT_LO];
        fields.command = CMD_NONE;
        fields.valid   = 1'b0;
        // Class requests to the interface only; index and value header checked
        if (req_kind == TYPE_CLASS && rcpt == RCPT_IFACE && fields.index == '0
            && kind == FEATURE_KIND)
        begin
            if (!dir_in && fields.req_code == SET_REPORT_CODE
                && fields.length == SHORT_LEN)
            begin
                if (ident == CMD_FEATURE_ID || ident == CTRL_NUM_ID)
                begin
                    // Subtype known only after data stage
                    fields.command = CMD_SELECT;
                    fields.valid   = 1'b1;
                end
            end
            else if (dir_in && fields.req_code == GET_REPORT_CODE)
                if (ident == STATUS_ID && fields.length == SHORT_LEN)
                begin
                    fields.command = CMD_STATUS;
                    fields.valid   = 1'b1;
                end
                else if (ident == CTRL_NUM_ID && fields.length == CTRL_NUM_LEN)
                begin
                    fields.command = CMD_GET_CTRL_NUM;
                    fields.valid   = 1'b1;
                end
        end
    end
endmodule

/* touch_feature_command_decoder_assertions.sv */
// Concurrent checks on the ports of the touch feature command decoder
`timescale 1ns/1ps
module touch_feature_command_decoder_assertions
(
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  setup_valid,
    input wire logic [7:0]            setup_req_type,
    input wire logic [7:0]            setup_req_code,
    input wire logic [15:0]           setup_value,
    input wire logic [15:0]           setup_index,
    input wire logic [15:0]           setup_length,
    input wire logic                  out_data_valid,
    input wire logic [7:0]            out_data,
    input wire logic                  touch_data_ready,
    input wire logic                  calibrate_busy,
    input wire logic                  ep0_stall,
    input wire logic                  cmd_done,
    input wire feature_pkg::command_t cmd_code,
    input wire logic [7:0]            cmd_arg,
    input wire logic                  reports_enabled,
    input wire logic                  tool_mode,
    input wire logic [7:0]            active_report_ident,
    input wire logic                  ep1_send,
    input wire logic                  ep0_send,
    input wire logic [7:0]            send_report_ident
);
    import feature_pkg::*;
    // ==========================================================
    // Idle tracking
    // Setups during a data stage are ignored, so only taken ones count
    logic pending;
    logic next_pending;
    logic taken;
    logic answer;

    always_comb
    begin
        answer       = ep0_stall || cmd_done;
        taken        = setup_valid && (!pending || answer);
        next_pending = taken ? 1'b1 : (answer ? 1'b0 : pending);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            pending <= 1'b0;
        else
            pending <= next_pending;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_status_done:
        assert property (taken && setup_req_type == GET_REQ_TYPE
            && setup_req_code == GET_REPORT_CODE && setup_value == 16'h0306
            && setup_index == 16'h0000 && setup_length == SHORT_LEN
            |=> cmd_done && !ep0_stall && cmd_code == CMD_STATUS)
        else $error("status query not completed");
    chk_ctrl_len_stall:
        assert property (taken && setup_req_type == GET_REQ_TYPE
            && setup_value == 16'h0305 && setup_length != CTRL_NUM_LEN |=> ep0_stall)
        else $error("controller number query with bad length not stalled");
    chk_index_stall:
        assert property (taken && setup_index != 16'h0000 |=> ep0_stall && !cmd_done)
        else $error("nonzero index not stalled");
    chk_kind_stall:
        assert property (taken && setup_value[15:8] != FEATURE_KIND |=> ep0_stall)
        else $error("non-feature value not stalled");
    chk_type_stall:
        assert property (taken && setup_req_type[TYPE_HI:TYPE_LO] != TYPE_CLASS
            |=> ep0_stall)
        else $error("non-class request not stalled");
    chk_touch_route:
        assert property (touch_data_ready && reports_enabled
            |=> ep0_send == $past(tool_mode) && ep1_send == !$past(tool_mode)
            && send_report_ident == ($past(tool_mode) ? tool_report_ident
                                                      : $past(active_report_ident)))
        else $error("touch report not routed as selected");
    chk_send_cause:
        assert property ((ep1_send || ep0_send)
            |-> $past(touch_data_ready) && $past(reports_enabled))
        else $error("report sent without enabled touch data");
    chk_one_report:
        assert property (active_report_ident == standard_report_ident
            || active_report_ident == dual_point_report_ident)
        else $error("active report identifier out of range");
    chk_reset_state:
        assert property ($rose(rst_n) |-> reports_enabled && !tool_mode
            && active_report_ident == standard_report_ident && !cmd_done && !ep0_stall)
        else $error("state after reset wrong");
    chk_answer_excl:
        assert property (!(ep0_stall && cmd_done))
        else $error("stall and done together");
endmodule

bind touch_feature_command_decoder touch_feature_command_decoder_assertions checker_i (
    .clock, .rst_n, .setup_valid, .setup_req_type, .setup_req_code, .setup_value,
    .setup_index, .setup_length, .out_data_valid, .out_data, .touch_data_ready,
    .calibrate_busy, .ep0_stall, .cmd_done, .cmd_code, .cmd_arg, .reports_enabled,
    .tool_mode, .active_report_ident, .ep1_send, .ep0_send, .send_report_ident);

/* usb_host_model.sv */
// Behavioural host issuing setup packets and data-stage bytes
`timescale 1ns/1ps
module usb_host_model
(
    input  wire logic   clock,
    output logic        setup_valid,
    output logic [7:0]  setup_req_type,
    output logic [7:0]  setup_req_code,
    output logic [15:0] setup_value,
    output logic [15:0] setup_index,
    output logic [15:0] setup_length,
    output logic        out_data_valid,
    output logic [7:0]  out_data
);
    initial
    begin
        {setup_valid, setup_req_type, setup_req_code, setup_value} = '0;
        {setup_index, setup_length, out_data_valid, out_data} = '0;
    end

    // Released fields go inverted so a stale packet never looks valid
    task automatic send_setup(input logic [7:0] rt, rc, input logic [15:0] val, idx, len);
        @(negedge clock);
        setup_valid    = 1'b1;
        setup_req_type = rt;
        setup_req_code = rc;
        setup_value    = val;
        setup_index    = idx;
        setup_length   = len;
        @(negedge clock);
        setup_valid    = 1'b0;
        setup_req_type = ~rt;
        setup_req_code = ~rc;
        setup_value    = ~val;
        setup_index    = ~idx;
        setup_length   = ~len;
    endtask

    task automatic send_data(input logic [63:0] bytes);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clock);
            out_data_valid = 1'b1;
            out_data       = bytes[8*i +: 8];
        end
        @(negedge clock);
        out_data_valid = 1'b0;
        out_data       = ~out_data;
    endtask
endmodule

/* touch_feature_command_decoder_tb_top.sv */
// Self-checking testbench for the touch feature command decoder
`timescale 1ns/1ps
module touch_feature_command_decoder_tb_top;
    import feature_pkg::*;

    logic        clock = 1'b0;
    logic        rst_n, touch_data_ready, calibrate_busy;
    logic        setup_valid, out_data_valid;
    logic [7:0]  setup_req_type, setup_req_code, out_data;
    logic [15:0] setup_value, setup_index, setup_length;
    logic        ep0_stall, cmd_done, reports_enabled, tool_mode, ep1_send, ep0_send;
    command_t    cmd_code;
    logic [7:0]  cmd_arg, active_report_ident, send_report_ident;
    int          bad_count = 0;
    int          checked = 0;

    always #12.5 clock = ~clock;

    touch_feature_command_decoder uut (.clock, .rst_n, .setup_valid, .setup_req_type,
        .setup_req_code, .setup_value, .setup_index, .setup_length, .out_data_valid,
        .out_data, .touch_data_ready, .calibrate_busy, .ep0_stall, .cmd_done, .cmd_code,
        .cmd_arg, .reports_enabled, .tool_mode, .active_report_ident, .ep1_send,
        .ep0_send, .send_report_ident);

    usb_host_model host (.clock, .setup_valid, .setup_req_type, .setup_req_code,
        .setup_value, .setup_index, .setup_length, .out_data_valid, .out_data);

    // ==========================================================
    // Shared tasks
    task automatic conclude();
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic run_cmd(input logic [7:0] rt, rc, input logic [15:0] val, idx, len,
                           input logic [63:0] data, input logic with_data, exp_stall);
        int n;
        host.send_setup(rt, rc, val, idx, len);
        if (with_data)
            host.send_data(data);
        n = 0;
        while (ep0_stall !== 1'b1 && cmd_done !== 1'b1 && n < 12)
        begin
            @(negedge clock);
            n++;
        end
        check(ep0_stall, exp_stall);
        check(cmd_done, !exp_stall);
    endtask

    task automatic set_cmd(input logic [15:0] val, input logic [63:0] data, input logic stall);
        run_cmd(SET_REQ_TYPE, SET_REPORT_CODE, val, 16'h0000, SHORT_LEN, data, 1'b1, stall);
    endtask

    task automatic sel(input logic [7:0] code, input logic stall);
        set_cmd(16'h0303, {24'h000000, code, 16'h0000, 8'h05, 8'h03}, stall);
    endtask

    task automatic touch(input logic exp_ep1, exp_ep0, input logic [7:0] ident);
        @(negedge clock);
        touch_data_ready = 1'b1;
        @(negedge clock);
        touch_data_ready = 1'b0;
        check(ep1_send, exp_ep1);
        check(ep0_send, exp_ep0);
        if (exp_ep1 || exp_ep0)
            check(send_report_ident, ident);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_state();
        check(reports_enabled, 1'b1);
        check(active_report_ident, standard_report_ident);
        check(tool_mode, 1'b0);
        check(cmd_code, CMD_NONE);
        touch(1'b1, 1'b0, standard_report_ident);
        set_cmd(16'h0303, 64'h0703, 1'b0);
        check(cmd_code, CMD_RESET);
    endtask

    task automatic t_selection();
        sel(SEL_PACKED, 1'b0);
        check(cmd_code, CMD_SELECT);
        check(cmd_arg, SEL_PACKED);
        check(active_report_ident, dual_point_report_ident);
        touch(1'b1, 1'b0, dual_point_report_ident);
        sel(SEL_TOOL, 1'b0);
        check(tool_mode, 1'b1);
        touch(1'b0, 1'b1, tool_report_ident);
        sel(SEL_RESTORE, 1'b0);
        check(tool_mode, 1'b0);
        touch(1'b1, 1'b0, dual_point_report_ident);
        sel(SEL_OFF, 1'b0);
        check(reports_enabled, 1'b0);
        touch(1'b0, 1'b0, 8'h00);
        sel(SEL_ON, 1'b0);
        check(reports_enabled, 1'b1);
        sel(SEL_STANDARD, 1'b0);
        touch(1'b1, 1'b0, standard_report_ident);
        sel(8'h04, 1'b1);
    endtask

    task automatic t_gets();
        run_cmd(GET_REQ_TYPE, GET_REPORT_CODE, 16'h0306, 16'h0000, SHORT_LEN, 64'h0, 1'b0, 1'b0);
        check(cmd_code, CMD_STATUS);
        run_cmd(GET_REQ_TYPE, GET_REPORT_CODE, 16'h0305, 16'h0000, CTRL_NUM_LEN, 64'h0, 1'b0,
                1'b0);
        check(cmd_code, CMD_GET_CTRL_NUM);
    endtask

    task automatic t_setup_stalls();
        logic [63:0] bad [9];
        bad = '{64'ha101_0306_0001_0008, 64'ha101_0206_0000_0008, 64'hc101_0306_0000_0008,
                64'ha001_0306_0000_0008, 64'ha102_0306_0000_0008, 64'ha101_0306_0000_0010,
                64'ha101_0305_0000_0008, 64'ha101_0309_0000_0008, 64'h2109_0303_0000_0009};
        foreach (bad[i])
            run_cmd(bad[i][63:56], bad[i][55:48], bad[i][47:32], bad[i][31:16], bad[i][15:0],
                    64'h0, 1'b0, 1'b1);
    endtask

    task automatic t_data_stage();
        set_cmd(16'h0303, 64'h0000_0002_0000_0505, 1'b1);
        set_cmd(16'h0303, 64'h0603, 1'b1);
        calibrate_busy = 1'b1;
        set_cmd(16'h0303, 64'h020403, 1'b1);
        calibrate_busy = 1'b0;
        set_cmd(16'h0303, 64'h020403, 1'b0);
        check(cmd_code, CMD_CALIBRATE);
        check(cmd_arg, 8'h02);
        set_cmd(16'h0305, 64'h090105, 1'b0);
        check(cmd_code, CMD_SET_CTRL_NUM);
        check(cmd_arg, 8'h09);
        set_cmd(16'h0303, 64'h0803, 1'b0);
        check(cmd_code, CMD_DEFAULTS);
        sel(SEL_PACKED, 1'b0);
        sel(SEL_TOOL, 1'b0);
        sel(SEL_OFF, 1'b0);
        set_cmd(16'h0303, 64'h0703, 1'b0);
        check(reports_enabled, 1'b1);
        check(tool_mode, 1'b0);
        check(active_report_ident, standard_report_ident);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        rst_n            = 1'b0;
        touch_data_ready = 1'b0;
        calibrate_busy   = 1'b0;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        t_reset_state();
        t_selection();
        t_gets();
        t_setup_stalls();
        t_data_stage();
        conclude();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        conclude();
    end
endmodule
